// ===== core/npic_ctrl.sv
/*
 * Nested priority interrupt controller top: priority registers, flag level
 * bits, request latches, halt/wait wake and entry sequencing.
 * Assumes a core reporting finished instructions and pushes in one step.
 */
// Operation
// - Highest software level, then fixed order wins
// - Unserved requests stay latched until chosen
// - Reset and trap outrank every level
// - Non-maskable taken always, push, level three
// - Non-maskable sources wake from halt
// - Trap instruction raises the trap entry
// - Reset is top priority, runs level three
// - Maskable taken if enabled and level above
// - Edge requests latched, cleared on entry
// - Pins of one group ORed together; here each vector takes a single grp_pins_i bit
// - Peripheral request needs flag and enable
// - Flag clear sequence drops pending latch
// - Any request wakes wait; halt needs capability
// - After halt, first served is wake-capable
// - Level held in flag bits five, three
// - Entry loads level from vector field
// - Four priority registers, reset to ones
// - Level zero writes keep old field
// - Raised level re-enters pending running vector
// - Instructions load or restore level bits
// - Masked and unmasked branch conditions
// - Flag register resets at level three
// - Entry after instruction, push, then fetch
module npic_ctrl
  import npic_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Sources
  input wire logic [NPIC_NVEC-1:0] edge_pins_i,
  input wire logic [NPIC_NVEC-1:0] grp_pins_i,
  input wire logic [NPIC_NVEC-1:0] per_flag_i,
  input wire logic [NPIC_NVEC-1:0] per_en_i,
  input wire logic [NPIC_NVEC-1:0] per_clr_i,
  // Core
  input wire npic_core_t core_i,
  output npic_entry_t entry_o,
  output logic [7:0] flags_o,
  output logic halted_o,
  output logic waiting_o,
  output logic masked_o,
  output logic unmasked_o
);

  // ***************************************************************
  // Pin synchronisers and edge latches
  // ***************************************************************
  logic [NPIC_NVEC-1:0] edge_s1_r, edge_s2_r, edge_d_r;
  logic [NPIC_NVEC-1:0] grp_s1_r, grp_s2_r;
  logic [NPIC_NVEC-1:0] flag_s1_r, flag_s2_r, en_s1_r, en_s2_r;
  logic [NPIC_NVEC-1:0] pend_r, pend_nxt, req_w, clr_w;
  logic [7:0] prio_r [4];
  logic [7:0] flags_r;
  logic [NPIC_NVEC-1:0] hwake_r;
  logic [NPIC_VW-1:0] cur_vec_r;
  logic in_isr_r;
  logic halted_r, waiting_r, after_halt_r, reset_pend_r, trap_pend_r;
  logic ack_r;
  logic [31:0] dat_r;
  npic_entry_t entry_r;
  logic [2*NPIC_NVEC-1:0] prio_flat;
  logic [1:0] lvl_w;
  logic [1:0] lvl_rank;
  logic found_w;
  logic [NPIC_VW-1:0] vec_w;
  logic [1:0] rank_w;
  logic [NPIC_NVEC-1:0] elig_w;

  // Two stages before any logic looks at outside levels, except per_clr_i, which the latches use directly
  always_ff @(posedge clk_i) begin
    edge_s1_r <= edge_pins_i;
    edge_s2_r <= edge_s1_r;
    edge_d_r <= edge_s2_r;
    grp_s1_r <= grp_pins_i;
    grp_s2_r <= grp_s1_r;
    flag_s1_r <= per_flag_i;
    flag_s2_r <= flag_s1_r;
    en_s1_r <= per_en_i;
    en_s2_r <= en_s1_r;
  end

  // ***************************************************************
  // Request latches
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < NPIC_NVEC; g++) begin : g_src
      assign req_w[g] = (edge_s2_r[g] & ~edge_d_r[g]) | grp_s2_r[g] |
                        (flag_s2_r[g] & en_s2_r[g]);
      assign clr_w[g] = per_clr_i[g] |
                        (entry_r.take && !entry_r.is_trap && !entry_r.is_reset &&
                         entry_r.vec == NPIC_VW'(g));
      // hold until served; a new edge wins over a clear
      assign pend_nxt[g] = req_w[g] | (pend_r[g] & ~clr_w[g]);
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // ***************************************************************
  // Arbitration
  // ***************************************************************
  assign prio_flat = {prio_r[3][3:0], prio_r[2], prio_r[1], prio_r[0]};
  assign lvl_w = {flags_r[NPIC_LVL_HI_POS], flags_r[NPIC_LVL_LO_POS]};
  assign lvl_rank = (lvl_w == NPIC_LVL0) ? 2'h0 : (lvl_w == NPIC_LVL1) ? 2'h1 :
                    (lvl_w == NPIC_LVL2) ? 2'h2 : 2'h3;
  // first after halt only wake-capable
  // Gate on halted_r too, so the pick made at the waking edge is capable
  assign elig_w = (halted_r || after_halt_r) ? (pend_r & hwake_r) : pend_r;

  npic_arbiter u_arb (
    .req_i(elig_w),
    .prio_i(prio_flat),
    .found_o(found_w),
    .vec_o(vec_w),
    .rank_o(rank_w)
  );

  // ***************************************************************
  // Entry sequencing
  // ***************************************************************
  // Maskable entries happen only at an instruction boundary or while sleeping, so
  // the core never sees such a request in the middle of an instruction.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      entry_r <= '0;
      reset_pend_r <= 1'b1;
      trap_pend_r <= 1'b0;
      in_isr_r <= 1'b0;
      cur_vec_r <= '0;
      after_halt_r <= 1'b0;
    end else begin
      entry_r <= '0;
      if (core_i.instr_done && core_i.op == NPIC_OP_TRAP) begin
        trap_pend_r <= 1'b1;
      end
      if (core_i.instr_done && core_i.op == NPIC_OP_RESTORE) begin
        in_isr_r <= 1'b0;
      end
      if (reset_pend_r) begin
        entry_r.take <= 1'b1;
        entry_r.is_reset <= 1'b1;
        reset_pend_r <= 1'b0;
      // no push for reset, push for trap
      end else if (trap_pend_r && !entry_r.take) begin
        entry_r.take <= 1'b1;
        entry_r.push <= 1'b1;
        entry_r.is_trap <= 1'b1;
        trap_pend_r <= 1'b0;
      end else if (found_w && rank_w > lvl_rank && !entry_r.take &&
                   (core_i.instr_done || halted_r || waiting_r)) begin
        entry_r.take <= 1'b1;
        entry_r.push <= 1'b1;
        entry_r.vec <= vec_w;
        in_isr_r <= 1'b1;
        cur_vec_r <= vec_w;
        after_halt_r <= 1'b0;
      end else if (halted_r && |(pend_r & hwake_r)) begin
        // Woken but not yet served: keep the first pick wake-capable
        after_halt_r <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Low power state
  // ***************************************************************
  // wait any, halt capable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halted_r <= 1'b0;
      waiting_r <= 1'b0;
    end else if (trap_pend_r || (halted_r && |(pend_r & hwake_r)) ||
                 (waiting_r && |pend_r)) begin
      halted_r <= 1'b0;
      waiting_r <= 1'b0;
    end else if (core_i.instr_done && core_i.op == NPIC_OP_HALT) begin
      halted_r <= 1'b1;
    end else if (core_i.instr_done && core_i.op == NPIC_OP_WAIT) begin
      waiting_r <= 1'b1;
    end
  end

  // ***************************************************************
  // Flag register level bits
  // ***************************************************************
  // bits five and three
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= NPIC_FLAG_RST;
    end else if (entry_r.take && (entry_r.is_reset || entry_r.is_trap)) begin
      {flags_r[NPIC_LVL_HI_POS], flags_r[NPIC_LVL_LO_POS]} <= NPIC_LVL3;
    end else if (entry_r.take) begin
      {flags_r[NPIC_LVL_HI_POS], flags_r[NPIC_LVL_LO_POS]} <=
        prio_flat[2*entry_r.vec +: 2];
    end else if (core_i.instr_done) begin
      unique case (core_i.op)
        NPIC_OP_UNMASK, NPIC_OP_HALT, NPIC_OP_WAIT:
          {flags_r[NPIC_LVL_HI_POS], flags_r[NPIC_LVL_LO_POS]} <= NPIC_LVL0;
        NPIC_OP_MASK, NPIC_OP_TRAP:
          {flags_r[NPIC_LVL_HI_POS], flags_r[NPIC_LVL_LO_POS]} <= NPIC_LVL3;
        NPIC_OP_RESTORE: flags_r <= core_i.pop_flags;
        NPIC_OP_NONE: flags_r <= flags_r;
      endcase
    end
  end

  // ***************************************************************
  // Register file and Wishbone slave
  // ***************************************************************
  logic wr_w;
  assign wr_w = cyc_i && stb_i && we_i && !ack_r && sel_i[0];

  generate
    for (g = 0; g < 4; g++) begin : g_prio
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          prio_r[g] <= NPIC_PRIO_RST;
        end else if (wr_w && adr_i == NPIC_OFS_PRIO0 + 8'(4 * g)) begin
          for (int f = 0; f < 4; f++) begin
            if (dat_i[2*f +: 2] != NPIC_LVL0) begin
              prio_r[g][2*f +: 2] <= dat_i[2*f +: 2];
            end
          end
          if (g == 3) begin
            prio_r[g][7:4] <= NPIC_PRIO3_RO;
          end
        end
      end
    end
  endgenerate

  // Halt wake capability, software-settable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hwake_r <= NPIC_HWAKE_RST;
    end else if (wr_w && adr_i == NPIC_OFS_HWEN) begin
      hwake_r[7:0] <= dat_i[7:0];
    end else if (wr_w && adr_i == NPIC_OFS_HWEN_HI) begin
      hwake_r[NPIC_NVEC-1:8] <= dat_i[NPIC_NVEC-9:0];
    end
  end

  // One-cycle answer; unmapped reads return zero, writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= cyc_i && stb_i && !ack_r;
      unique case (adr_i)
        NPIC_OFS_PRIO0: dat_r <= {24'h0, prio_r[0]};
        NPIC_OFS_PRIO1: dat_r <= {24'h0, prio_r[1]};
        NPIC_OFS_PRIO2: dat_r <= {24'h0, prio_r[2]};
        NPIC_OFS_PRIO3: dat_r <= {24'h0, prio_r[3]};
        NPIC_OFS_FLAG: dat_r <= {24'h0, flags_r};
        NPIC_OFS_STAT: dat_r <= {18'h0, pend_r};
        NPIC_OFS_HWEN: dat_r <= {24'h0, hwake_r[7:0]};
        NPIC_OFS_HWEN_HI: dat_r <= {26'h0, hwake_r[NPIC_NVEC-1:8]};
        default: dat_r <= '0;
      endcase
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      masked_o <= 1'b1;
      unmasked_o <= 1'b0;
    end else begin
      masked_o <= (lvl_w == NPIC_LVL3);
      unmasked_o <= (lvl_w != NPIC_LVL3);
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign entry_o = entry_r;
  assign flags_o = flags_r;
  assign halted_o = halted_r;
  assign waiting_o = waiting_r;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_reset_lvl3;
    @(posedge clk_i) disable iff (rst_i)
      entry_r.take && entry_r.is_reset |=>
        flags_r[NPIC_LVL_HI_POS] && flags_r[NPIC_LVL_LO_POS];
  endproperty
  a_reset_lvl3: assert property (p_reset_lvl3) else $error("reset entry not level 3");

  property p_nmi_lvl3;
    @(posedge clk_i) disable iff (rst_i)
      entry_r.take && entry_r.is_trap |=> lvl_w == NPIC_LVL3;
  endproperty
  a_nmi_lvl3: assert property (p_nmi_lvl3) else $error("trap entry not level 3");

  property p_trap_raise;
    @(posedge clk_i) disable iff (rst_i)
      core_i.instr_done && core_i.op == NPIC_OP_TRAP && !reset_pend_r
        |=> ##[0:2] entry_r.take && entry_r.is_trap;
  endproperty
  a_trap_raise: assert property (p_trap_raise) else $error("trap not entered");

  property p_above_lvl;
    @(posedge clk_i) disable iff (rst_i)
      $rose(entry_r.take) && entry_r.push && !entry_r.is_trap
        |-> $past(rank_w) > $past(lvl_rank);
  endproperty
  a_above_lvl: assert property (p_above_lvl) else $error("entry not above level");

  property p_load_field;
    @(posedge clk_i) disable iff (rst_i)
      entry_r.take && !entry_r.is_trap && !entry_r.is_reset
        |=> lvl_w == $past(prio_flat[2*entry_r.vec +: 2]);
  endproperty
  a_load_field: assert property (p_load_field) else $error("level not from field");

  property p_lvl0_keep;
    @(posedge clk_i) disable iff (rst_i)
      wr_w && adr_i == NPIC_OFS_PRIO0 && dat_i[5:4] == NPIC_LVL0
        |=> prio_r[0][5:4] == $past(prio_r[0][5:4]);
  endproperty
  a_lvl0_keep: assert property (p_lvl0_keep) else $error("level 0 written");

  property p_ro_nibble;
    @(posedge clk_i) disable iff (rst_i) prio_r[3][7:4] == NPIC_PRIO3_RO;
  endproperty
  a_ro_nibble: assert property (p_ro_nibble) else $error("read-only nibble changed");

  property p_halt_wake;
    @(posedge clk_i) disable iff (rst_i)
      halted_r && |(pend_r & hwake_r) |=> !halted_r;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt not woken");

  property p_unmask;
    @(posedge clk_i) disable iff (rst_i)
      core_i.instr_done && core_i.op == NPIC_OP_UNMASK && !entry_r.take
        |=> lvl_w == NPIC_LVL0;
  endproperty
  a_unmask: assert property (p_unmask) else $error("unmask did not lower level");

  c_trap: cover property (@(posedge clk_i) entry_r.take && entry_r.is_trap);
  c_entry: cover property (@(posedge clk_i) entry_r.take && entry_r.push && !entry_r.is_trap);
  c_halt: cover property (@(posedge clk_i) $fell(halted_r));

endmodule : npic_ctrl

// ===== core/npic_pkg.sv
/*
 * Package of the nested priority interrupt controller: register map, level
 * encodings, instruction codes and the bundles that travel between blocks.
 * Assumes a classic Wishbone slave with 8-bit data in the low byte lane.
 */
package npic_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int NPIC_NVEC = 14;
  localparam int NPIC_VW = 4;

  // ***************************************************************
  // Register map, word offsets in bytes
  // ***************************************************************
  localparam logic [7:0] NPIC_OFS_PRIO0 = 8'h00;
  localparam logic [7:0] NPIC_OFS_PRIO1 = 8'h04;
  localparam logic [7:0] NPIC_OFS_PRIO2 = 8'h08;
  localparam logic [7:0] NPIC_OFS_PRIO3 = 8'h0c;
  localparam logic [7:0] NPIC_OFS_FLAG = 8'h10;
  localparam logic [7:0] NPIC_OFS_STAT = 8'h14;
  localparam logic [7:0] NPIC_OFS_HWEN = 8'h18;
  localparam logic [7:0] NPIC_OFS_HWEN_HI = 8'h1c;

  // ***************************************************************
  // Reset values and field layout
  // ***************************************************************
  localparam logic [7:0] NPIC_PRIO_RST = 8'hff;
  localparam logic [3:0] NPIC_PRIO3_RO = 4'hf;
  localparam logic [7:0] NPIC_FLAG_RST = 8'hea;
  localparam int NPIC_LVL_HI_POS = 5;
  localparam int NPIC_LVL_LO_POS = 3;
  // Vectors 1..5 can wake from halt by default
  localparam logic [13:0] NPIC_HWAKE_RST = 14'h003e;

  // Level encodings of the two level bits
  localparam logic [1:0] NPIC_LVL0 = 2'h2;
  localparam logic [1:0] NPIC_LVL1 = 2'h1;
  localparam logic [1:0] NPIC_LVL2 = 2'h0;
  localparam logic [1:0] NPIC_LVL3 = 2'h3;

  // Flag-changing instructions reported by the core
  typedef enum logic [2:0] {
    NPIC_OP_NONE,
    NPIC_OP_UNMASK,
    NPIC_OP_MASK,
    NPIC_OP_HALT,
    NPIC_OP_WAIT,
    NPIC_OP_TRAP,
    NPIC_OP_RESTORE
  } npic_op_t;

  // Core-side instruction report
  typedef struct packed {
    logic instr_done;
    npic_op_t op;
    logic [7:0] pop_flags;
  } npic_core_t;

  // Entry request to the core
  typedef struct packed {
    logic take;
    logic push;
    logic [NPIC_VW-1:0] vec;
    logic is_trap;
    logic is_reset;
  } npic_entry_t;

endpackage : npic_pkg

// ===== core/npic_arbiter.sv
/*
 * Combinational two-step arbiter: software level first, then fixed order.
 * Assumes requests already gated by enables; the caller compares rank with level; higher index wins ties.
 */
module npic_arbiter
  import npic_pkg::*;
(
  input wire logic [NPIC_NVEC-1:0] req_i,
  input wire logic [2*NPIC_NVEC-1:0] prio_i,
  output logic found_o,
  output logic [NPIC_VW-1:0] vec_o,
  output logic [1:0] rank_o
);

  // Map the level encoding onto a plain ordered rank
  function automatic logic [1:0] npic_rank(input logic [1:0] enc);
    unique case (enc)
      NPIC_LVL0: npic_rank = 2'h0;
      NPIC_LVL1: npic_rank = 2'h1;
      NPIC_LVL2: npic_rank = 2'h2;
      default: npic_rank = 2'h3;
    endcase
  endfunction : npic_rank

  always_comb begin
    found_o = 1'b0;
    vec_o = '0;
    rank_o = '0;
    for (int i = 0; i < NPIC_NVEC; i++) begin
      if (req_i[i] && (!found_o || npic_rank(prio_i[2*i +: 2]) > rank_o ||
          (npic_rank(prio_i[2*i +: 2]) == rank_o && i > int'(vec_o)))) begin
        found_o = 1'b1;
        vec_o = NPIC_VW'(i);
        rank_o = npic_rank(prio_i[2*i +: 2]);
      end
    end
  end

endmodule : npic_arbiter

// ===== verif/npic_core_model.sv
/*
 * Behavioural CPU core facing the controller: finishes an instruction
 * every fourth cycle and reports one queued flag-changing op with it.
 * Assumes the bench queues ops with op_vld_i and waits for op_ack_o.
 */
module npic_core_model
  import npic_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic halted_i,
  input wire logic waiting_i,
  input wire logic op_vld_i,
  input wire npic_op_t op_i,
  input wire logic [7:0] pop_i,
  output npic_core_t core_o,
  output logic op_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r;
  always_ff @(posedge clk_i) begin
    cnt_r <= rst_i ? 2'h0 : cnt_r + 2'h1;
    op_ack_o <= 1'b0;
    // Idle flags bus carries junk so nothing relies on stale values
    core_o <= '{instr_done: 1'b0, op: NPIC_OP_NONE, pop_flags: ~pop_i};
    // A stopped core reports nothing until the controller wakes it
    if (!rst_i && cnt_r == 2'h3 && !halted_i && !waiting_i) begin
      core_o.instr_done <= 1'b1;
      if (op_vld_i) begin
        core_o.op <= op_i;
        core_o.pop_flags <= pop_i;
        op_ack_o <= 1'b1;
      end
    end
  end
endmodule : npic_core_model

// ===== verif/nested_priority_interrupt_ctrl_tb.sv
/*
 * Self-checking bench of the interrupt controller: Wishbone register
 * access, trap, nesting, masking, wait and halt wake-up.
 * Assumes the core model above and a one-cycle Wishbone ack.
 */
module nested_priority_interrupt_ctrl_tb;
  import npic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, halted_o, waiting_o, masked_o, unmasked_o, op_vld = 1'b0, op_ack;
  logic [13:0] edge_pins_i = '0, grp_pins_i = '0, per_flag_i = '0, per_en_i = '0;
  logic [13:0] per_clr_i = '0;
  npic_core_t core_i;
  npic_entry_t entry_o;
  logic [7:0] flags_o, pop = 8'h00, rd;
  npic_op_t op = NPIC_OP_NONE;
  int errors = 0, tests_run = 0;

  always #20 clk_i = ~clk_i;
  npic_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .edge_pins_i(edge_pins_i), .grp_pins_i(grp_pins_i), .per_flag_i(per_flag_i),
    .per_en_i(per_en_i), .per_clr_i(per_clr_i), .core_i(core_i), .entry_o(entry_o),
    .flags_o(flags_o), .halted_o(halted_o), .waiting_o(waiting_o), .masked_o(masked_o),
    .unmasked_o(unmasked_o));
  npic_core_model core_u (.clk_i(clk_i), .rst_i(rst_i), .halted_i(halted_o),
    .waiting_i(waiting_o), .op_vld_i(op_vld), .op_i(op), .pop_i(pop), .core_o(core_i),
    .op_ack_o(op_ack));

  // ***************************************************************
  // Bus, core and compare tasks
  // ***************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // Branch outputs trail the flag register by one cycle
  task automatic chk_lvl(input logic [1:0] exp);
    @(posedge clk_i);
    #1;
    chk({30'h0, flags_o[5], flags_o[3]}, {30'h0, exp}, "level bits");
    chk({31'h0, masked_o}, {31'h0, exp == 2'h3}, "masked branch");
    chk({31'h0, unmasked_o}, {31'h0, exp != 2'h3}, "unmasked branch");
  endtask : chk_lvl
  // Starts on an edge, holds the request until ack is sampled, idles one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o[7:0];
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, ack_o}, 32'h0, "ack not single cycle");
  endtask : wb
  // Returns just after the edge at which the controller sees the op
  task automatic core_op(input npic_op_t o, input logic [7:0] p);
    op <= o; pop <= p; op_vld <= 1'b1;
    do @(posedge clk_i); while (op_ack !== 1'b1);
    op_vld <= 1'b0;
    #1;
  endtask : core_op
  // Flags pass two sync stages: let them drain before the clear pulse
  task automatic drop_flag(input logic [13:0] m);
    @(posedge clk_i);
    per_flag_i <= 14'h0;
    repeat (3) @(posedge clk_i);
    per_clr_i <= m;
    @(posedge clk_i);
    per_clr_i <= 14'h0;
  endtask : drop_flag
  task automatic expect_entry(input logic [3:0] v, input logic t, input logic r);
    int n;
    n = 0;
    do begin @(posedge clk_i); #1; n++; end while (entry_o.take !== 1'b1 && n < 60);
    chk({27'h0, entry_o.take, entry_o.vec}, {27'h0, 1'b1, v}, "entry vec");
    chk({29'h0, entry_o.is_trap, entry_o.is_reset, entry_o.push}, {29'h0, t, r, !r}, "kind");
    repeat (3) @(posedge clk_i);
    #1;
  endtask : expect_entry
  task automatic expect_none(input int cyc);
    repeat (cyc) begin
      @(posedge clk_i); #1;
      chk({31'h0, entry_o.take}, 32'h0, "unexpected entry");
    end
  endtask : expect_none
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_reset;
    repeat (2) @(posedge clk_i);
    #1;
    chk({24'h0, flags_o}, 32'hea, "flag reset");
    @(posedge clk_i);
    rst_i <= 1'b0;
    expect_entry(4'h0, 1'b0, 1'b1);
    chk_lvl(NPIC_LVL3);
    $display("reset done");
  endtask : t_reset
  task automatic t_regs;
    wb(1'b0, NPIC_OFS_PRIO1, 8'h00); chk({24'h0, rd}, 32'hff, "prio1 reset");
    wb(1'b1, NPIC_OFS_PRIO0, 8'h64);
    wb(1'b0, NPIC_OFS_PRIO0, 8'h00); chk({24'h0, rd}, 32'h74, "level0 write kept");
    wb(1'b1, NPIC_OFS_PRIO3, 8'h05);
    wb(1'b0, NPIC_OFS_PRIO3, 8'h00); chk({24'h0, rd}, 32'hf5, "prio3 upper ones");
    wb(1'b1, NPIC_OFS_FLAG, 8'h00);
    wb(1'b0, NPIC_OFS_FLAG, 8'h00); chk({24'h0, rd}, 32'hea, "flag read only");
    wb(1'b0, NPIC_OFS_HWEN, 8'h00); chk({24'h0, rd}, 32'h3e, "wake enables");
    wb(1'b1, 8'h20, 8'h55);
    wb(1'b0, 8'h20, 8'h00); chk({24'h0, rd}, 32'h0, "unmapped read");
    $display("registers done");
  endtask : t_regs
  task automatic t_trap;
    // Trap is taken at the disabled level
    core_op(NPIC_OP_TRAP, 8'h00);
    expect_entry(4'h0, 1'b1, 1'b0);
    chk_lvl(NPIC_LVL3);
    core_op(NPIC_OP_RESTORE, 8'he2); chk_lvl(NPIC_LVL0);
    $display("trap done");
  endtask : t_trap
  task automatic t_nest;
    @(posedge clk_i);
    edge_pins_i <= 14'h0030; grp_pins_i <= 14'h2000;
    repeat (3) @(posedge clk_i);
    edge_pins_i <= 14'h0; grp_pins_i <= 14'h0;
    expect_entry(4'h5, 1'b0, 1'b0);
    chk_lvl(NPIC_LVL3);
    core_op(NPIC_OP_RESTORE, 8'he2);
    expect_entry(4'h4, 1'b0, 1'b0);
    core_op(NPIC_OP_RESTORE, 8'he2);
    expect_entry(4'hd, 1'b0, 1'b0);
    chk_lvl(NPIC_LVL1);
    repeat (8) @(posedge clk_i);
    core_op(NPIC_OP_RESTORE, 8'he2);
    expect_none(30);
    $display("nesting done");
  endtask : t_nest
  task automatic t_mask_clr;
    core_op(NPIC_OP_MASK, 8'h00); chk_lvl(NPIC_LVL3);
    @(posedge clk_i);
    per_en_i <= 14'h0180; per_flag_i <= 14'h0100;
    expect_none(30);
    drop_flag(14'h0100);
    core_op(NPIC_OP_UNMASK, 8'h00); chk_lvl(NPIC_LVL0);
    expect_none(40);
    @(posedge clk_i);
    per_flag_i <= 14'h0100;
    expect_entry(4'h8, 1'b0, 1'b0);
    drop_flag(14'h0100);
    core_op(NPIC_OP_RESTORE, 8'he2);
    $display("mask and clear done");
  endtask : t_mask_clr
  task automatic t_wait;
    core_op(NPIC_OP_WAIT, 8'h00);
    chk({31'h0, waiting_o}, 32'h1, "waiting"); chk_lvl(NPIC_LVL0);
    @(posedge clk_i);
    per_flag_i <= 14'h0080;
    expect_entry(4'h7, 1'b0, 1'b0);
    chk({31'h0, waiting_o}, 32'h0, "woken");
    drop_flag(14'h0080);
    core_op(NPIC_OP_RESTORE, 8'he2);
    $display("wait done");
  endtask : t_wait
  task automatic t_halt;
    core_op(NPIC_OP_HALT, 8'h00);
    chk({31'h0, halted_o}, 32'h1, "halted"); chk_lvl(NPIC_LVL0);
    @(posedge clk_i);
    edge_pins_i <= 14'h0204;
    repeat (3) @(posedge clk_i);
    edge_pins_i <= 14'h0;
    expect_entry(4'h2, 1'b0, 1'b0);
    chk({31'h0, halted_o}, 32'h0, "woken");
    core_op(NPIC_OP_RESTORE, 8'he2);
    expect_entry(4'h9, 1'b0, 1'b0);
    $display("halt done");
  endtask : t_halt

  initial begin
    t_reset;
    t_regs;
    t_trap;
    t_nest;
    t_mask_clr;
    t_wait;
    t_halt;
    wrap_up;
  end
  // Watchdog well past the few hundred cycles the tests need
  initial begin
    #(40 * 20000);
    errors++;
    wrap_up;
  end
endmodule : nested_priority_interrupt_ctrl_tb
